// ### logic/card_cmd_pkg.sv
package card_cmd_pkg;
	// register map (byte addresses)
	localparam logic [11:0] ADDR_CMD    = 12'h000;
	localparam logic [11:0] ADDR_DATA   = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_RESP   = 12'h00C;
	localparam logic [11:0] ADDR_FILE   = 12'h010;

	// instruction codes
	localparam logic [7:0] INS_INCREASE = 8'h32;
	localparam logic [7:0] INS_VERIFY   = 8'h20;
	localparam logic [7:0] INS_CHANGE   = 8'h24;
	localparam logic [7:0] INS_UNLOCK   = 8'h2C;
	localparam logic [7:0] AM_TAG_INC   = 8'h84;

	// parameter coding
	localparam logic [2:0] P1_SFI_PREFIX = 3'h4;
	localparam logic [7:0] PIN_REF       = 8'h01;
	localparam logic [7:0] LC_PIN        = 8'h08;
	localparam logic [7:0] LC_PIN_PAIR   = 8'h10;
	localparam logic [7:0] LC_MAX        = 8'h7F;
	localparam int         BUF_DEPTH     = 128;
	localparam int         REC_COUNT     = 4;

	// reset values, persistent except RECLEN_RESET which every card reset loads; secret values are arbitrary
	localparam logic [1:0]  RETRIES_INIT = 2'h3;
	localparam logic [3:0]  UNLOCK_INIT  = 4'hA;
	localparam logic [63:0] PIN_RESET    = 64'h3132_3334_3536_3738;
	localparam logic [63:0] UNLOCK_CODE  = 64'h3837_3635_3433_3231;
	localparam logic [6:0]  RECLEN_RESET = 7'h04;

	// status words
	localparam logic [15:0] SW_OK        = 16'h9000;
	localparam logic [11:0] SW_RETRY_HI  = 12'h63C;
	localparam logic [15:0] SW_BLOCKED   = 16'h6983;
	localparam logic [15:0] SW_COND      = 16'h6985;
	localparam logic [15:0] SW_SECURITY  = 16'h6982;
	localparam logic [15:0] SW_NO_EF     = 16'h6986;
	localparam logic [15:0] SW_LENGTH    = 16'h6700;
	localparam logic [15:0] SW_P1P2      = 16'h6A86;
	localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
	localparam logic [15:0] SW_REF       = 16'h6A88;
	localparam logic [15:0] SW_INS       = 16'h6D00;
	localparam logic [15:0] SW_MAX       = 16'h9850;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_DECODE = 4'h2,
		ST_SUM    = 4'h4,
		ST_STORE  = 4'h8
	} state_type;

	typedef struct packed {
		logic [7:0] am_ins;
		logic [7:0] am_tag;
		logic [1:0] rsv;
		logic       needs_pin;
		logic       selected;
		logic [4:0] short_file_identifier;
		logic [6:0] reclen;
	} file_cfg_type;

	typedef struct packed {
		logic [1:0]  rsv;
		logic [1:0]  retries;
		logic        blocked;
		logic        enabled;
		logic        verified;
		logic        busy;
		logic [7:0]  resp_len;
		logic [15:0] sw;
	} status_type;
endpackage

// ### logic/card_cmd_core.sv
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module card_cmd_core
	import card_cmd_pkg::*;
(
	// clock and resets
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        por_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// security level for other file operations
	output logic             pin_verified
);
	state_type    state_reg, state_next;
	file_cfg_type file_reg;
	logic [7:0]   in_buf [0:BUF_DEPTH-1];
	logic [7:0]   rec_mem [0:REC_COUNT-1][0:BUF_DEPTH-1];
	logic [7:0]   ins_reg, p1_reg, p2_reg, lc_reg;
	logic [7:0]   in_cnt_reg, resp_idx_reg, resp_len_reg, resp_len_next;
	logic [15:0]  sw_reg, sw_next;
	logic [6:0]   idx_reg, idx_next;
	logic         carry_reg, carry_next, verified_reg, verified_next;
	logic [1:0]   cur_rec_reg, cur_rec_next, retries_reg, retries_next;
	logic [3:0]   unlock_reg, unlock_next;
	logic [63:0]  pin_reg, pin_next, first_pin, second_pin;
	logic         enabled_reg, enabled_next, rec_wr;
	logic [31:0]  prdata_reg, rd_mux;
	logic         pready_reg, pslverr_reg;

	function automatic logic [15:0] retry_sw(input logic [3:0] left);
		return {SW_RETRY_HI, left};
	endfunction

	function automatic logic p2_coding_ok(input logic [7:0] p2);
		return (p2[6:5] == 2'h0) && (p2[4:0] != 5'h00);
	endfunction

	// apb decode
	wire access   = psel & penable;
	wire done     = access & pready_reg;
	wire wr_done  = done & pwrite;
	wire rd_done  = done & ~pwrite;
	wire busy     = (state_reg != ST_IDLE);
	wire sel_cmd  = (paddr == ADDR_CMD);
	wire sel_data = (paddr == ADDR_DATA);
	wire sel_stat = (paddr == ADDR_STATUS);
	wire sel_resp = (paddr == ADDR_RESP);
	wire sel_file = (paddr == ADDR_FILE);
	wire mapped   = sel_cmd | sel_data | sel_stat | sel_resp | sel_file;
	wire wr_block = pwrite & busy & (sel_cmd | sel_data | sel_file);
	wire cmd_wr   = wr_done & sel_cmd & ~busy;
	wire data_wr  = wr_done & sel_data & ~busy & (in_cnt_reg < 8'(BUF_DEPTH));
	wire file_wr  = wr_done & sel_file & ~busy;

	// pin state and comparisons
	wire       blocked   = (retries_reg == 2'h0);
	wire       first_ok  = (first_pin == pin_reg);
	wire       unlock_ok = (first_pin == UNLOCK_CODE);
	wire       pin_p_ok  = (p1_reg == 8'h00) && p2_coding_ok(p2_reg);
	wire [1:0] retry_dec = retries_reg - 2'h1;
	wire [3:0] unlock_dec = unlock_reg - 4'h1;

	// add value datapath
	wire [1:0] oldest   = cur_rec_reg - 2'h1;
	wire [6:0] val_off  = file_reg.reclen - lc_reg[6:0];
	wire [6:0] val_idx  = idx_reg - val_off;
	wire [7:0] src_byte = rec_mem[cur_rec_reg][idx_reg];
	wire [7:0] val_byte = (idx_reg >= val_off) ? in_buf[val_idx] : 8'h00;
	wire [8:0] sum9     = {1'b0, src_byte} + {1'b0, val_byte} + {8'h00, carry_reg};
	wire       am_ok    = (file_reg.am_tag == AM_TAG_INC) && (file_reg.am_ins == INS_INCREASE);
	wire       pin_sat  = ~file_reg.needs_pin | verified_reg | ~enabled_reg;
	wire       p1_cur   = (p1_reg == 8'h00);
	wire       p1_sfi   = (p1_reg[7:5] == P1_SFI_PREFIX);
	wire [7:0] reclen8  = {1'b0, file_reg.reclen};

	// response: record bytes first, then the added value
	wire [7:0] resp_off  = resp_idx_reg - reclen8;
	wire [7:0] resp_byte = (resp_idx_reg < reclen8) ? rec_mem[cur_rec_reg][resp_idx_reg[6:0]]
		: in_buf[resp_off[6:0]];

	status_type status_word;
	assign status_word = '{rsv: 2'h0, retries: retries_reg, blocked: blocked,
		enabled: enabled_reg, verified: verified_reg, busy: busy,
		resp_len: resp_len_reg, sw: sw_reg};

	assign rd_mux = sel_cmd  ? {lc_reg, p2_reg, p1_reg, ins_reg} :
		sel_data ? {24'h0, in_cnt_reg} :
		sel_stat ? status_word :
		sel_resp ? {24'h0, resp_byte} :
		sel_file ? file_reg : 32'h0;

	always_comb begin
		for (int k = 0; k < 8; k++) begin
			first_pin[63-8*k -: 8]  = in_buf[k];
			second_pin[63-8*k -: 8] = in_buf[k+8];
		end
	end

	always_comb begin
		state_next    = state_reg;
		sw_next       = sw_reg;
		resp_len_next = resp_len_reg;
		idx_next      = idx_reg;
		carry_next    = carry_reg;
		cur_rec_next  = cur_rec_reg;
		verified_next = verified_reg;
		retries_next  = retries_reg;
		unlock_next   = unlock_reg;
		pin_next      = pin_reg;
		enabled_next  = enabled_reg;
		rec_wr        = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (cmd_wr) begin
					state_next    = ST_DECODE;
					resp_len_next = 8'h00;
				end
			end
			ST_DECODE: begin
				state_next = ST_IDLE;
				if (ins_reg == INS_INCREASE) begin
					if (p2_reg != 8'h00 || !(p1_cur || p1_sfi))
						sw_next = SW_P1P2;
					else if (p1_sfi && p1_reg[4:0] != file_reg.short_file_identifier)
						sw_next = SW_NOT_FOUND;
					else if (p1_cur && !file_reg.selected)
						sw_next = SW_NO_EF;
					else if (lc_reg == 8'h00 || lc_reg > LC_MAX || lc_reg > reclen8
						|| in_cnt_reg != lc_reg)
						sw_next = SW_LENGTH;
					else if (!am_ok || !pin_sat)
						sw_next = SW_SECURITY;
					else begin
						state_next = ST_SUM;
						idx_next   = file_reg.reclen - 7'h01;
						carry_next = 1'b0;
					end
				end else if (ins_reg == INS_VERIFY) begin
					if (!pin_p_ok)
						sw_next = SW_P1P2;
					else if (p2_reg != PIN_REF)
						sw_next = SW_REF;
					else if (lc_reg == 8'h00)
						sw_next = blocked ? SW_BLOCKED : retry_sw({2'h0, retries_reg});
					else if (lc_reg != LC_PIN || in_cnt_reg != LC_PIN)
						sw_next = SW_LENGTH;
					else if (blocked)
						sw_next = SW_BLOCKED;
					else if (!enabled_reg)
						sw_next = SW_COND;
					else if (first_ok) begin
						retries_next  = RETRIES_INIT;
						verified_next = 1'b1;
						sw_next       = SW_OK;
					end else begin
						retries_next  = retry_dec;
						verified_next = 1'b0;
						sw_next       = retry_sw({2'h0, retry_dec});
					end
				end else if (ins_reg == INS_CHANGE) begin
					if (!pin_p_ok)
						sw_next = SW_P1P2;
					else if (p2_reg != PIN_REF)
						sw_next = SW_REF;
					else if (lc_reg != LC_PIN_PAIR || in_cnt_reg != LC_PIN_PAIR)
						sw_next = SW_LENGTH;
					else if (blocked)
						sw_next = SW_BLOCKED;
					else if (!enabled_reg)
						sw_next = SW_COND;
					else if (first_ok) begin
						retries_next = RETRIES_INIT;
						pin_next     = second_pin;
						sw_next      = SW_OK;
					end else begin
						retries_next  = retry_dec;
						verified_next = 1'b0;
						sw_next       = retry_sw({2'h0, retry_dec});
					end
				end else if (ins_reg == INS_UNLOCK) begin
					if (!pin_p_ok)
						sw_next = SW_P1P2;
					else if (p2_reg != PIN_REF)
						sw_next = SW_REF;
					else if (lc_reg != LC_PIN_PAIR || in_cnt_reg != LC_PIN_PAIR)
						sw_next = SW_LENGTH;
					else if (unlock_reg == 4'h0)
						sw_next = SW_BLOCKED;
					else if (unlock_ok) begin
						retries_next  = RETRIES_INIT;
						unlock_next   = UNLOCK_INIT;
						pin_next      = second_pin;
						enabled_next  = 1'b1;
						verified_next = 1'b1;
						sw_next       = SW_OK;
					end else begin
						unlock_next = unlock_dec;
						sw_next     = retry_sw(unlock_dec);
					end
				end else
					sw_next = SW_INS;
			end
			// first pass only proves the sum fits, so a refused add writes nothing
			ST_SUM: begin
				carry_next = sum9[8];
				idx_next   = idx_reg - 7'h01;
				if (idx_reg == 7'h00) begin
					if (sum9[8]) begin
						state_next = ST_IDLE;
						sw_next    = SW_MAX;
					end else begin
						state_next = ST_STORE;
						idx_next   = file_reg.reclen - 7'h01;
						carry_next = 1'b0;
					end
				end
			end
			// serial add from the last byte, value right-aligned
			ST_STORE: begin
				rec_wr     = 1'b1;
				carry_next = sum9[8];
				idx_next   = idx_reg - 7'h01;
				if (idx_reg == 7'h00) begin
					// oldest becomes record 1, answer length
					state_next    = ST_IDLE;
					cur_rec_next  = oldest;
					sw_next       = SW_OK;
					resp_len_next = reclen8 + lc_reg;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// apb handshake: one wait state, writes land on the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= access & ~pready_reg;
			pslverr_reg <= access & ~pready_reg & (~mapped | wr_block);
			if (access & ~pready_reg)
				prdata_reg <= rd_mux;
		end
	end

	// session state: cleared by every card reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= ST_IDLE;
			ins_reg      <= 8'h00;
			p1_reg       <= 8'h00;
			p2_reg       <= 8'h00;
			lc_reg       <= 8'h00;
			in_cnt_reg   <= 8'h00;
			resp_idx_reg <= 8'h00;
			resp_len_reg <= 8'h00;
			sw_reg       <= SW_OK;
			idx_reg      <= 7'h00;
			carry_reg    <= 1'b0;
			verified_reg <= 1'b0;
			file_reg     <= '{am_ins: 8'h00, am_tag: 8'h00, rsv: 2'h0, needs_pin: 1'b0,
				selected: 1'b0, short_file_identifier: 5'h00, reclen: RECLEN_RESET};
		end else begin
			state_reg    <= state_next;
			sw_reg       <= sw_next;
			resp_len_reg <= resp_len_next;
			idx_reg      <= idx_next;
			carry_reg    <= carry_next;
			verified_reg <= verified_next;
			if (cmd_wr) begin
				{lc_reg, p2_reg, p1_reg, ins_reg} <= pwdata;
				resp_idx_reg <= 8'h00;
			end else if (rd_done & sel_resp & (resp_idx_reg < resp_len_reg))
				resp_idx_reg <= resp_idx_reg + 8'h01;
			if (state_reg == ST_DECODE)
				in_cnt_reg <= 8'h00;
			else if (data_wr)
				in_cnt_reg <= in_cnt_reg + 8'h01;
			if (file_wr)
				file_reg <= pwdata;
		end
	end

	// buffered data is kept after a command so the added value can be read back
	always_ff @(posedge pclk) begin
		if (data_wr)
			in_buf[in_cnt_reg[6:0]] <= pwdata[7:0];
	end

	// nonvolatile state, only power-on clears it
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			retries_reg <= RETRIES_INIT;
			unlock_reg  <= UNLOCK_INIT;
			pin_reg     <= PIN_RESET;
			enabled_reg <= 1'b1;
			cur_rec_reg <= 2'h0;
			for (int r = 0; r < REC_COUNT; r++)
				for (int b = 0; b < BUF_DEPTH; b++)
					rec_mem[r][b] <= 8'h00;
		end else begin
			retries_reg <= retries_next;
			unlock_reg  <= unlock_next;
			pin_reg     <= pin_next;
			enabled_reg <= enabled_next;
			cur_rec_reg <= cur_rec_next;
			if (rec_wr)
				rec_mem[oldest][idx_reg] <= sum9[7:0];
		end
	end

	assign prdata       = prdata_reg;
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;
	assign pin_verified = verified_reg;

	wire dec_verify = (state_reg == ST_DECODE) && (ins_reg == INS_VERIFY) && pin_p_ok
		&& (p2_reg == PIN_REF);

	property p_verify_ok;
		@(posedge pclk) disable iff (!presetn)
		(dec_verify && sw_next == SW_OK) |=> (retries_reg == RETRIES_INIT) && verified_reg;
	endproperty
	a_verify_ok: assert property (p_verify_ok) else $error("attempts not restored");

	property p_verify_bad;
		@(posedge pclk) disable iff (!presetn)
		(dec_verify && lc_reg == LC_PIN && sw_next[15:4] == SW_RETRY_HI)
		|=> (retries_reg == 2'($past(retries_reg) - 2'h1))
		&& (sw_reg == {SW_RETRY_HI, 2'h0, retries_reg});
	endproperty
	a_verify_bad: assert property (p_verify_bad) else $error("wrong pin not counted");

	property p_blocked;
		@(posedge pclk) disable iff (!presetn)
		(dec_verify && blocked && lc_reg == LC_PIN && in_cnt_reg == LC_PIN)
		|=> sw_reg == SW_BLOCKED && retries_reg == 2'h0;
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked pin not refused");

	property p_query;
		@(posedge pclk) disable iff (!presetn)
		(dec_verify && lc_reg == 8'h00 && !blocked)
		|=> sw_reg == {SW_RETRY_HI, 2'h0, $past(retries_reg)} && $stable(retries_reg);
	endproperty
	a_query: assert property (p_query) else $error("retry query wrong");

	property p_overflow;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_SUM && idx_reg == 7'h00 && sum9[8])
		|=> state_reg == ST_IDLE && sw_reg == SW_MAX && $stable(cur_rec_reg);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not refused");

	property p_rotate;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_STORE && idx_reg == 7'h00)
		|=> cur_rec_reg == $past(oldest) && resp_len_reg == reclen8 + lc_reg;
	endproperty
	a_rotate: assert property (p_rotate) else $error("record not rotated");

	property p_access;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_DECODE && ins_reg == INS_INCREASE && (!am_ok || !pin_sat))
		|=> state_reg == ST_IDLE ##1 state_reg != ST_SUM;
	endproperty
	a_access: assert property (p_access) else $error("add value not refused");

	property p_change_bad;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ST_DECODE && ins_reg == INS_CHANGE && sw_next[15:4] == SW_RETRY_HI)
		|=> $stable(pin_reg) && retries_reg == 2'($past(retries_reg) - 2'h1);
	endproperty
	a_change_bad: assert property (p_change_bad) else $error("pin changed on failure");

	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_reg) |=> pready_reg ##1 !pready_reg;
	endproperty
	a_ready: assert property (p_ready) else $error("apb answer timing");
endmodule

// ### testbench/terminal_model.sv
`timescale 1ns/1ns
module terminal_model (
	// clock
	input  wire logic        pclk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end

	// request stays put until pready is sampled high; the bench timeout cuts a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// a released data bus must not look like a held copy
		pwdata <= ~d;
	endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
	import card_cmd_pkg::*;
	typedef struct packed {
		logic [32:0] v;
		logic [32:0] m;
	} note_type;
	logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, pin_verified;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, rec, val;
	logic [63:0] pin_now, pin_new;
	logic [7:0]  dbuf [0:15];
	note_type    notes [$];
	note_type    nt;
	int          fail_count, checks_done, cycles, i;

	card_cmd_core card_cmd_core_i (.pclk(pclk), .presetn(presetn), .por_n(por_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_verified(pin_verified));
	terminal_model terminal_model_i (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task results;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			results();
		end
	end

	// oldest note is matched against each completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			if (notes.size() > 0)
				nt = notes.pop_front();
			else
				nt = '{v: 33'h0, m: {33{1'b1}}};
			checks_done++;
			if ((({pslverr, prdata} ^ nt.v) & nt.m) !== 33'h0) begin
				fail_count++;
				$display("unexpected at %0t: got %h expected %h", $time, {pslverr, prdata}, nt.v);
			end
		end
	end

	task automatic chk(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] ev, input logic [32:0] em);
		notes.push_back(note_type'{ev, em});
		terminal_model_i.apb(w, a, d, rdata);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
		xfer(1'b1, a, d, {err, 32'h0}, {1'b1, 32'h0});
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
		xfer(1'b0, a, 32'h0, {1'b0, exp}, {1'b1, mask});
	endtask

	// push n data bytes, start, poll until idle, then check the status word
	task automatic cmd(input logic [7:0] ins, p1, p2, lc, input int n,
		input logic [15:0] sw, input logic [1:0] att);
		int k;
		for (k = 0; k < n; k++)
			wr(ADDR_DATA, {24'h0, dbuf[k]}, 1'b0);
		wr(ADDR_CMD, {lc, p2, p1, ins}, 1'b0);
		k = 0;
		do begin
			rd(ADDR_STATUS, 32'h0, 32'h0);
			k++;
		end while (rdata[24] !== 1'b0 && k < 500);
		// busy is in the mask so that a command which never finishes cannot pass
		rd(ADDR_STATUS, {2'h0, att, att == 2'h0, 1'b1, 10'h0, sw}, 32'h3D00_FFFF);
	endtask

	task automatic pins(input logic [63:0] a, b);
		int k;
		for (k = 0; k < 8; k++) begin
			dbuf[k] = a[63-8*k -: 8];
			dbuf[k+8] = b[63-8*k -: 8];
		end
	endtask

	task automatic add(input logic [7:0] p1, input int lc, input logic [31:0] v,
		input logic [15:0] sw);
		int k;
		for (k = 0; k < lc; k++)
			dbuf[k] = v[8*(lc-1-k) +: 8];
		cmd(INS_INCREASE, p1, 8'h00, 8'(lc), lc, sw, 2'h3);
	endtask

	task automatic resp(input logic [31:0] r, v, input int lc);
		int k;
		rd(ADDR_STATUS, {8'h00, 8'(4 + lc), SW_OK}, 32'h00FF_FFFF);
		for (k = 0; k < 4; k++)
			rd(ADDR_RESP, {24'h0, r[31-8*k -: 8]}, 32'h0000_00FF);
		for (k = 0; k < lc; k++)
			rd(ADDR_RESP, {24'h0, v[8*(lc-1-k) +: 8]}, 32'h0000_00FF);
	endtask

	task automatic reset_card;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	function automatic logic [63:0] rnd64();
		return {$urandom, $urandom};
	endfunction

	initial begin
		void'($urandom(32'hAFDF));
		presetn = 1'b0;
		por_n = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		rd(ADDR_STATUS, 32'h3400_9000, 32'hFFFF_FFFF);
		rd(ADDR_FILE, 32'h0000_0004, 32'hFFFF_FFFF);
		xfer(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
		wr(12'h0F0, 32'h1, 1'b1);
		cmd(INS_VERIFY, 8'h00, PIN_REF, 8'h00, 0, {SW_RETRY_HI, 4'h3}, 2'h3);
		pins(rnd64(), 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, {SW_RETRY_HI, 4'h2}, 2'h2);
		reset_card();
		cmd(INS_VERIFY, 8'h00, PIN_REF, 8'h00, 0, {SW_RETRY_HI, 4'h2}, 2'h2);
		pin_now = PIN_RESET;
		pins(pin_now, 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, SW_OK, 2'h3);
		chk(pin_verified, 1'b1);
		cmd(INS_VERIFY, 8'h01, PIN_REF, 8'h00, 0, SW_P1P2, 2'h3);
		cmd(INS_VERIFY, 8'h00, 8'h41, 8'h00, 0, SW_P1P2, 2'h3);
		cmd(INS_VERIFY, 8'h00, 8'h02, 8'h00, 0, SW_REF, 2'h3);
		cmd(INS_VERIFY, 8'h00, PIN_REF, 8'h04, 4, SW_LENGTH, 2'h3);
		cmd(8'hB0, 8'h00, 8'h00, 8'h00, 0, SW_INS, 2'h3);
		// cyclic file, short id 5, guarded by the PIN and listing the add-value code
		wr(ADDR_FILE, 32'h3284_3284, 1'b0);
		rd(ADDR_FILE, 32'h3284_3284, 32'hFFFF_FFFF);
		val = $urandom & 32'h0000_FFFF;
		rec = val;
		add(8'h00, 2, val, SW_OK);
		resp(rec, val, 2);
		val = $urandom & 32'h0000_00FF;
		rec = rec + val;
		add(8'h85, 1, val, SW_OK);
		resp(rec, val, 1);
		add(8'h00, 4, 32'hFFFF_FFFF, SW_MAX);
		rec = rec + 1;
		add(8'h00, 1, 32'h1, SW_OK);
		resp(rec, 32'h1, 1);
		add(8'h40, 1, 32'h1, SW_P1P2);
		cmd(INS_INCREASE, 8'h00, 8'h01, 8'h01, 1, SW_P1P2, 2'h3);
		add(8'h86, 1, 32'h1, SW_NOT_FOUND);
		add(8'h00, 0, 32'h0, SW_LENGTH);
		cmd(INS_INCREASE, 8'h00, 8'h00, 8'h80, 0, SW_LENGTH, 2'h3);
		wr(ADDR_FILE, 32'h3285_3284, 1'b0);
		add(8'h00, 1, 32'h1, SW_SECURITY);
		wr(ADDR_FILE, 32'h3384_3284, 1'b0);
		add(8'h00, 1, 32'h1, SW_SECURITY);
		reset_card();
		wr(ADDR_FILE, 32'h3284_3284, 1'b0);
		add(8'h00, 1, 32'h1, SW_SECURITY);
		chk(pin_verified, 1'b0);
		pins(pin_now, 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, SW_OK, 2'h3);
		rec = rec + 2;
		add(8'h00, 1, 32'h2, SW_OK);
		resp(rec, 32'h2, 1);
		// command and data writes are refused while an add value is running
		wr(ADDR_DATA, 32'h3, 1'b0);
		wr(ADDR_CMD, {8'h01, 8'h00, 8'h00, INS_INCREASE}, 1'b0);
		wr(ADDR_CMD, {8'h01, 8'h00, 8'h00, INS_INCREASE}, 1'b1);
		wr(ADDR_DATA, 32'h7, 1'b1);
		repeat (20) @(posedge pclk);
		rec = rec + 3;
		resp(rec, 32'h3, 1);
		// replace frame: P1 zero, length 16, old value then new value
		pin_new = rnd64();
		pins(pin_now, pin_new);
		cmd(INS_CHANGE, 8'h00, PIN_REF, LC_PIN_PAIR, 16, SW_OK, 2'h3);
		pins(pin_now, 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, {SW_RETRY_HI, 4'h2}, 2'h2);
		pin_now = pin_new;
		pins(rnd64(), rnd64());
		cmd(INS_CHANGE, 8'h00, PIN_REF, LC_PIN_PAIR, 16, {SW_RETRY_HI, 4'h1}, 2'h1);
		pins(pin_now, 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, SW_OK, 2'h3);
		for (i = 0; i < 3; i++) begin
			pins(rnd64(), 64'h0);
			cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, {SW_RETRY_HI, 4'(2-i)}, 2'(2-i));
		end
		pins(pin_now, 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, SW_BLOCKED, 2'h0);
		chk(pin_verified, 1'b0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, 8'h00, 0, SW_BLOCKED, 2'h0);
		pins(pin_now, rnd64());
		cmd(INS_CHANGE, 8'h00, PIN_REF, LC_PIN_PAIR, 16, SW_BLOCKED, 2'h0);
		pins(rnd64(), rnd64());
		cmd(INS_UNLOCK, 8'h00, PIN_REF, LC_PIN_PAIR, 16, {SW_RETRY_HI, 4'h9}, 2'h0);
		pin_new = rnd64();
		pins(UNLOCK_CODE, pin_new);
		cmd(INS_UNLOCK, 8'h00, PIN_REF, LC_PIN_PAIR, 16, SW_OK, 2'h3);
		pins(pin_new, 64'h0);
		cmd(INS_VERIFY, 8'h00, PIN_REF, LC_PIN, 8, SW_OK, 2'h3);
		results();
	end
endmodule
